/* File: rtl/sfb_status_bank.sv */
// Status-flag bank of the welding power source: five read-only 16-bit
// words that the robot controller polls at addresses F100 to F104.
// Assumes a protocol engine that presents one access per request and
// power-source logic that drives the flag inputs synchronously.
//
// Overview of operation
// - Whole word of group one is reserved and always reads zero.
// - Group two bit 0 toggles as a 0.5 Hz heartbeat while running.
// - Group two bit 1 is high while the power source is ready.
// - Group two bits 2, 3, 4: arc stable, current flow, main current.
// - Group two bit 5 is collision protection, zero means collision.
// - Group two bit 8 touch, bit 9 torch body; bits 6-7 reserved.
// - Group two bit 10 command out of range, bit 11 correction.
// - Group two bits 12-14: process active, motion release, wire stuck.
// - Group three bits 0-4 hold the process code; bits 5-7 reserved.
// - Group three bits 8, 9, 11: internal selection, valid, running.
// - Group three bits 14-15 hold the process-image variant code.
// - Group four bits 0 and 1 report the two stabilizers active.
// - Group four bits 5-7 hold the feeder motor type code.
// - Motor codes 0, 1, 2 only; codes 3 to 7 are never produced.
// - Group four bit 14 tip short circuit, bit 15 nozzle touched.
// - Group five sensor flags at bits 0, 1, 2 and 4.
// - Group five bits 11-12 safety code; bit 13 reserved.
// - Group five bit 14 notification pending, bit 15 not ready.
// - Process code 0 is internal selection, 1 to 8 processes.
// - Process-image code 00 means the standard image layout.
`timescale 1ns/10ps
`default_nettype none

`include "sfb_params.svh"

module sfb_status_bank #(
  parameter int unsigned HB_HALF_CYC = `SFB_HB_HALF_CYC,
  parameter logic [1:0]  PROC_IMAGE  = `SFB_IMAGE_STD
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire sfb_pkg::sfb_flags_t flags,
  input  wire sfb_pkg::sfb_req_t   req,
  output var  sfb_pkg::sfb_rsp_t   rsp,
  output var  logic                heartbeat
);

  localparam int unsigned NG = `SFB_NUM_GROUPS;

  // Implemented-bit mask of each group, in address order
  localparam logic [15:0] MASKS [NG] = '{
    `SFB_MASK_G1, `SFB_MASK_G2, `SFB_MASK_G3, `SFB_MASK_G4, `SFB_MASK_G5
  };

  sfb_pkg::sfb_state_t st_r;
  sfb_pkg::sfb_state_t st_nxt;

  logic        hb_tick;
  logic [15:0] raw   [NG];
  logic [15:0] words [NG];
  logic [15:0] offs;
  logic        hit;
  logic [2:0]  idx;

  // Half-period enable for the heartbeat; long count is a parameter so
  // a simulation can shorten it
  sfb_tick_div #(
    .DIV (HB_HALF_CYC)
  ) u_hb_div (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (hb_tick)
  );

  // Group one carries no status; its whole word stays zero
  always_comb begin
    raw[0] = `SFB_WORD_RESET;
  end

  // Group two: liveness, arc and process flags
  always_comb begin
    raw[1] = `SFB_WORD_RESET;
    raw[1][`SFB_G2_HEARTBEAT]  = st_r.heartbeat;
    raw[1][`SFB_G2_READY]      = flags.ps_ready;
    raw[1][`SFB_G2_ARC_STABLE] = flags.arc_stable;
    raw[1][`SFB_G2_CUR_FLOW]   = flags.current_flow;
    raw[1][`SFB_G2_MAIN_CUR]   = flags.main_current;
    // Inverted so a broken link or zero word also reads as collision
    raw[1][`SFB_G2_COLL_N]     = ~flags.collision;
    raw[1][`SFB_G2_TOUCH]      = flags.touch;
    raw[1][`SFB_G2_TORCH_CONN] = flags.torch_connected;
    raw[1][`SFB_G2_CMD_RANGE]  = flags.cmd_out_of_range;
    raw[1][`SFB_G2_CORR_RANGE] = flags.corr_out_of_range;
    raw[1][`SFB_G2_PROC_ACT]   = flags.process_active;
    raw[1][`SFB_G2_MOTION_REL] = flags.motion_release;
    raw[1][`SFB_G2_WIRE_STICK] = flags.wire_stuck;
  end

  // Group three: process code, selection state and image variant
  always_comb begin
    raw[2] = `SFB_WORD_RESET;
    raw[2][`SFB_G3_PROC_LSB +: 5] = st_r.proc_code;
    raw[2][`SFB_G3_PARAM_INT]     = flags.param_internal;
    raw[2][`SFB_G3_CHAR_VALID]    = flags.char_valid;
    raw[2][`SFB_G3_PROC_RUN]      = flags.process_run;
    raw[2][`SFB_G3_IMAGE_LSB +: 2] = PROC_IMAGE;
  end

  // Group four: stabilizers, motor type and torch contact events
  always_comb begin
    raw[3] = `SFB_WORD_RESET;
    raw[3][`SFB_G4_STAB_PEN]       = flags.stab_penetration;
    raw[3][`SFB_G4_STAB_ARC]       = flags.stab_arclength;
    raw[3][`SFB_G4_MOTOR_LSB +: 3] = st_r.motor_type;
    raw[3][`SFB_G4_TIP_SHORT]      = flags.tip_short;
    raw[3][`SFB_G4_NOZZLE]         = flags.nozzle_touch;
  end

  // Group five: sensors, safety code and readiness faults
  always_comb begin
    raw[4] = `SFB_WORD_RESET;
    raw[4][`SFB_G5_SNS1]            = flags.sensor[0];
    raw[4][`SFB_G5_SNS2]            = flags.sensor[1];
    raw[4][`SFB_G5_SNS3]            = flags.sensor[2];
    raw[4][`SFB_G5_SNS4]            = flags.sensor[3];
    raw[4][`SFB_G5_SAFETY_LSB +: 2] = flags.safety;
    raw[4][`SFB_G5_NOTIFY]          = flags.notification;
    raw[4][`SFB_G5_NOT_READY]       = flags.not_ready;
  end

  // One masked word register per group; reserved bits cannot escape
  for (genvar g = 0; g < NG; g++) begin : g_word
    sfb_status_word #(
      .MASK (MASKS[g])
    ) u_word (
      .sys_clk (sys_clk),
      .reset   (reset),
      .raw     (raw[g]),
      .word    (words[g])
    );
  end

  // Address decode of the five consecutive word addresses
  always_comb begin
    offs = req.addr - `SFB_ADDR_BASE;
    hit  = (offs < 16'(NG));
    idx  = offs[2:0];
  end

  // Next state: heartbeat, sanitised codes and the access answer
  always_comb begin
    st_nxt = st_r;

    // Heartbeat flips every half period from reset release onward
    if (hb_tick) begin
      st_nxt.heartbeat = ~st_r.heartbeat;
    end

    // Unused process codes keep the last legal value so the robot never
    // sees a code it cannot decode
    if (flags.proc_code <= `SFB_PROC_MAX) begin
      st_nxt.proc_code = flags.proc_code;
    end

    // Reserved motor codes are held off the bus the same way
    if (flags.motor_type <= `SFB_MOTOR_MAX) begin
      st_nxt.motor_type = flags.motor_type;
    end

    // Answer pulses last one cycle
    st_nxt.rsp.rd_valid   = 1'b0;
    st_nxt.rsp.rd_err     = 1'b0;
    st_nxt.rsp.wr_refused = 1'b0;

    // A read returns the word or zero with an error for a bad address;
    // read data stands until the next read
    if (req.rd_en) begin
      st_nxt.rsp.rd_valid = 1'b1;
      if (hit) begin
        st_nxt.rsp.rdata = words[idx];
      end else begin
        st_nxt.rsp.rdata  = `SFB_WORD_RESET;
        st_nxt.rsp.rd_err = 1'b1;
      end
    end

    // The bank is read-only: writes change nothing and are only reported
    if (req.wr_en) begin
      st_nxt.rsp.wr_refused = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r.heartbeat      <= 1'b0;
      st_r.proc_code      <= `SFB_PROC_INTERNAL;
      st_r.motor_type     <= `SFB_MOTOR_DEFAULT;
      st_r.rsp.rd_valid   <= 1'b0;
      st_r.rsp.rd_err     <= 1'b0;
      st_r.rsp.wr_refused <= 1'b0;
      st_r.rsp.rdata      <= `SFB_WORD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign rsp       = st_r.rsp;
  assign heartbeat = st_r.heartbeat;

endmodule

`default_nettype wire

/* File: rtl/sfb_params.svh */
// Constants of the welding power source status-flag bank: addresses,
// field positions, reserved-bit masks and heartbeat timing.
// Assumes it is included by bare name by the package and the modules.
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH

// Holding-register word addresses of the five status groups
`define SFB_ADDR_BASE      16'hF100
`define SFB_ADDR_G1        16'hF100
`define SFB_ADDR_G2        16'hF101
`define SFB_ADDR_G3        16'hF102
`define SFB_ADDR_G4        16'hF103
`define SFB_ADDR_G5        16'hF104
`define SFB_NUM_GROUPS     5
`define SFB_WORD_W         16

// Group 2 field positions
`define SFB_G2_HEARTBEAT   0
`define SFB_G2_READY       1
`define SFB_G2_ARC_STABLE  2
`define SFB_G2_CUR_FLOW    3
`define SFB_G2_MAIN_CUR    4
`define SFB_G2_COLL_N      5
`define SFB_G2_TOUCH       8
`define SFB_G2_TORCH_CONN  9
`define SFB_G2_CMD_RANGE   10
`define SFB_G2_CORR_RANGE  11
`define SFB_G2_PROC_ACT    12
`define SFB_G2_MOTION_REL  13
`define SFB_G2_WIRE_STICK  14

// Group 3 field positions
`define SFB_G3_PROC_LSB    0
`define SFB_G3_PARAM_INT   8
`define SFB_G3_CHAR_VALID  9
`define SFB_G3_PROC_RUN    11
`define SFB_G3_IMAGE_LSB   14

// Group 4 field positions
`define SFB_G4_STAB_PEN    0
`define SFB_G4_STAB_ARC    1
`define SFB_G4_MOTOR_LSB   5
`define SFB_G4_TIP_SHORT   14
`define SFB_G4_NOZZLE      15

// Group 5 field positions
`define SFB_G5_SNS1        0
`define SFB_G5_SNS2        1
`define SFB_G5_SNS3        2
`define SFB_G5_SNS4        4
`define SFB_G5_SAFETY_LSB  11
`define SFB_G5_NOTIFY      14
`define SFB_G5_NOT_READY   15

// Implemented-bit masks; every other bit reads as zero
`define SFB_MASK_G1        16'h0000
`define SFB_MASK_G2        16'h7F3F
`define SFB_MASK_G3        16'hCB1F
`define SFB_MASK_G4        16'hC0E3
`define SFB_MASK_G5        16'hD817

// Code values and reset values
`define SFB_PROC_INTERNAL  5'h00
`define SFB_PROC_MAX       5'h08
`define SFB_MOTOR_DEFAULT  3'h0
`define SFB_MOTOR_MAX      3'h2
`define SFB_IMAGE_STD      2'h0
`define SFB_WORD_RESET     16'h0000

// Heartbeat: 0.5 Hz square wave, rate given in millihertz
`define SFB_CLK_HZ         40000000
`define SFB_HB_RATE_MHZ    500
`define SFB_HB_HALF_CYC    ((`SFB_CLK_HZ / (2 * `SFB_HB_RATE_MHZ)) * 1000)

`endif

/* File: rtl/sfb_pkg.sv */
// Types of the status-flag bank: flag inputs, register request,
// register answer and the state record of the top module.
// Assumes sfb_params.svh sits on the include path.
`include "sfb_params.svh"

package sfb_pkg;

  // Live flags from the power-source control logic
  typedef struct packed {
    logic       ps_ready;
    logic       arc_stable;
    logic       current_flow;
    logic       main_current;
    logic       collision;
    logic       touch;
    logic       torch_connected;
    logic       cmd_out_of_range;
    logic       corr_out_of_range;
    logic       process_active;
    logic       motion_release;
    logic       wire_stuck;
    logic [4:0] proc_code;
    logic       param_internal;
    logic       char_valid;
    logic       process_run;
    logic       stab_penetration;
    logic       stab_arclength;
    logic [2:0] motor_type;
    logic       tip_short;
    logic       nozzle_touch;
    logic [3:0] sensor;
    logic [1:0] safety;
    logic       notification;
    logic       not_ready;
  } sfb_flags_t;

  // One register access from the robot-side protocol engine
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sfb_req_t;

  // Answer to a register access
  typedef struct packed {
    logic        rd_valid;
    logic        rd_err;
    logic        wr_refused;
    logic [15:0] rdata;
  } sfb_rsp_t;

  // Whole state of the top module
  typedef struct packed {
    logic       heartbeat;
    logic [4:0] proc_code;
    logic [2:0] motor_type;
    sfb_rsp_t   rsp;
  } sfb_state_t;

endpackage

/* File: rtl/sfb_tick_div.sv */
// Clock divider giving a one-cycle enable pulse every DIV cycles.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module sfb_tick_div #(
  parameter int unsigned DIV = 4
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  output var  logic tick
);

  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_nxt;

  // Wrap at the last count and flag it for one cycle
  always_comb begin
    tick_nxt = (cnt_r == LAST);
    cnt_nxt  = tick_nxt ? '0 : cnt_r + CW'(1);
  end

  // Counter and pulse register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/sfb_status_word.sv */
// One read-only status word: samples its raw value each cycle and
// forces every bit outside MASK to zero.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

`include "sfb_params.svh"

module sfb_status_word #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] raw,
  output var  logic [15:0] word
);

  logic [15:0] word_nxt;

  // Reserved positions never leak, whatever the source drives
  always_comb begin
    word_nxt = raw & MASK;
  end

  // Word register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      word <= `SFB_WORD_RESET;
    end else begin
      word <= word_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: tb/sfb_bank_sva.sv */
// Port checker of the status-flag bank.
// Assumes it is bound onto sfb_status_bank with one clock.
`timescale 1ns/10ps
`default_nettype none

module sfb_bank_sva #(
  parameter int unsigned HB_HALF_CYC = 8,
  parameter logic [1:0]  PROC_IMAGE  = 2'h0
) (
  input wire logic                sys_clk,
  input wire logic                reset,
  input wire sfb_pkg::sfb_flags_t flags,
  input wire sfb_pkg::sfb_req_t   req,
  input wire sfb_pkg::sfb_rsp_t   rsp,
  input wire logic                heartbeat
);
  logic [31:0] hb_cnt_r;
  logic        hb_seen_r;
  logic        hb_last_r;
  wire logic   rd_g1 = req.rd_en && req.addr == 16'hF100;
  wire logic   rd_g2 = req.rd_en && req.addr == 16'hF101;
  wire logic   rd_g3 = req.rd_en && req.addr == 16'hF102;
  wire logic   rd_g4 = req.rd_en && req.addr == 16'hF103;
  wire logic   rd_g5 = req.rd_en && req.addr == 16'hF104;
  wire logic   rd_bad = req.rd_en && (req.addr < 16'hF100 ||
                                      req.addr > 16'hF104);
  wire logic   hb_moved = hb_last_r != heartbeat;

  // Cycles since the heartbeat last moved; first half period is longer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hb_cnt_r <= '0;
      hb_seen_r <= 1'b0;
      hb_last_r <= 1'b0;
    end else begin
      hb_last_r <= heartbeat;
      hb_cnt_r <= hb_moved ? 32'h0 : hb_cnt_r + 32'h1;
      hb_seen_r <= hb_seen_r | hb_moved;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_grp_one_zero: assert property (rd_g1 |=> rsp.rdata == 16'h0000)
    else $error("group one not zero");
  a_hb_period: assert property (hb_seen_r && hb_moved |->
    hb_cnt_r == HB_HALF_CYC - 1) else $error("heartbeat period wrong");
  a_hb_bound: assert property (hb_cnt_r < HB_HALF_CYC + 2)
    else $error("heartbeat stalled");
  a_ready_bit: assert property (rd_g2 && !$past(reset) |=>
    rsp.rdata[1] == $past(flags.ps_ready, 2)) else $error("ready bit");
  a_coll_low: assert property (rd_g2 && !$past(reset) |=>
    rsp.rdata[5] == !$past(flags.collision, 2)) else $error("collision");
  a_hb_in_word: assert property (rd_g2 && !$past(reset) |=>
    rsp.rdata[0] == $past(heartbeat, 2)) else $error("heartbeat bit");
  a_rd_answer: assert property (req.rd_en |=> rsp.rd_valid)
    else $error("read not answered");
  a_g2_reserved: assert property (rd_g2 |=>
    (rsp.rdata & 16'h80C0) == 16'h0000) else $error("group two reserved");
  a_g3_fields: assert property (rd_g3 |=>
    rsp.rdata[15:14] == PROC_IMAGE && rsp.rdata[4:0] <= 5'h08 &&
    (rsp.rdata & 16'h34E0) == 16'h0000) else $error("group three");
  a_g4_fields: assert property (rd_g4 |=>
    rsp.rdata[7:5] <= 3'h2 && (rsp.rdata & 16'h3F1C) == 16'h0000)
    else $error("group four");
  a_g5_reserved: assert property (rd_g5 |=>
    (rsp.rdata & 16'h27E8) == 16'h0000) else $error("group five");
  a_bad_addr: assert property (rd_bad |=> rsp.rd_err &&
    rsp.rdata == 16'h0000) else $error("unmapped read");
  a_write_refused: assert property (req.wr_en |=> rsp.wr_refused)
    else $error("write not refused");
endmodule

bind sfb_status_bank sfb_bank_sva #(
  .HB_HALF_CYC(HB_HALF_CYC),
  .PROC_IMAGE (PROC_IMAGE)
) sfb_bank_sva_inst (
  .sys_clk  (sys_clk),
  .reset    (reset),
  .flags    (flags),
  .req      (req),
  .rsp      (rsp),
  .heartbeat(heartbeat)
);

`default_nettype wire

/* File: tb/sfb_robot_model.sv */
// Robot-side poller: one access per go pulse, after delay idle cycles.
// Assumes the bank answers one cycle after the taking edge.
`timescale 1ns/10ps
`default_nettype none

module sfb_robot_model (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              go,
  input  wire logic              write,
  input  wire logic [3:0]        delay,
  input  wire logic [15:0]       addr,
  output var  sfb_pkg::sfb_req_t req,
  input  wire sfb_pkg::sfb_rsp_t rsp,
  output var  logic              done,
  output var  logic [15:0]       data,
  output var  logic              err
);
  logic [3:0] cnt_r;
  logic       busy_r;
  logic       pend_r;

  // Strobes last one cycle, since each high cycle is one access
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req <= '0;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      done <= 1'b0;
      data <= 16'h0000;
      err <= 1'b0;
    end else begin
      req.rd_en <= 1'b0;
      req.wr_en <= 1'b0;
      done <= 1'b0;
      if (go && !busy_r) begin
        busy_r <= 1'b1;
        pend_r <= 1'b0;
        cnt_r <= delay;
        req.addr <= addr;
        req.wdata <= ~addr;
      end else if (busy_r && !pend_r) begin
        if (cnt_r != 4'h0) begin
          cnt_r <= cnt_r - 4'h1;
        end else begin
          pend_r <= 1'b1;
          req.rd_en <= !write;
          req.wr_en <= write;
        end
      end else if (pend_r && (rsp.rd_valid || rsp.wr_refused)) begin
        busy_r <= 1'b0;
        pend_r <= 1'b0;
        done <= 1'b1;
        data <= rsp.rdata;
        err <= rsp.rd_err | rsp.wr_refused;
        req.addr <= ~req.addr; // Idle address shows no stale value
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench of the status-flag bank.
// Assumes the robot model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int unsigned HB   = 8;
  localparam logic [1:0]  PIMG = 2'h1;
  logic                sys_clk = 1'b0;
  logic                reset = 1'b1;
  sfb_pkg::sfb_flags_t flags = '0;
  sfb_pkg::sfb_req_t   req;
  sfb_pkg::sfb_rsp_t   rsp;
  logic                heartbeat;
  logic                go = 1'b0;
  logic                write = 1'b0;
  logic                done;
  logic                err;
  logic [3:0]          delay = 4'h0;
  logic [15:0]         addr = 16'h0000;
  logic [15:0]         data;
  logic [4:0]          proc_l = 5'h00;
  logic [2:0]          mot_l = 3'h0;
  int                  fail_count = 0;
  int                  comparisons = 0;

  always #12.5 sys_clk = ~sys_clk;

  sfb_status_bank #(.HB_HALF_CYC(HB), .PROC_IMAGE(PIMG)) sfb_status_bank_inst (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .flags    (flags),
    .req      (req),
    .rsp      (rsp),
    .heartbeat(heartbeat)
  );

  sfb_robot_model sfb_robot_model_inst (
    .sys_clk(sys_clk),
    .reset  (reset),
    .go     (go),
    .write  (write),
    .delay  (delay),
    .addr   (addr),
    .req    (req),
    .rsp    (rsp),
    .done   (done),
    .data   (data),
    .err    (err)
  );

  // Word layout expected from the flags; heartbeat bit left as zero
  function automatic logic [15:0] exp_word(input int g);
    case (g)
      1: exp_word = {1'b0, flags.wire_stuck, flags.motion_release,
        flags.process_active, flags.corr_out_of_range,
        flags.cmd_out_of_range, flags.torch_connected, flags.touch, 2'h0,
        ~flags.collision, flags.main_current, flags.current_flow,
        flags.arc_stable, flags.ps_ready, 1'b0};
      2: exp_word = {PIMG, 2'h0, flags.process_run, 1'b0, flags.char_valid,
        flags.param_internal, 3'h0, proc_l};
      3: exp_word = {flags.nozzle_touch, flags.tip_short, 6'h00, mot_l,
        3'h0, flags.stab_arclength, flags.stab_penetration};
      4: exp_word = {flags.not_ready, flags.notification, 1'b0,
        flags.safety, 6'h00, flags.sensor[3], 1'b0, flags.sensor[2:0]};
      default: exp_word = 16'h0000;
    endcase
  endfunction

  task automatic results();
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One access through the robot model, bounded wait for its answer
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [3:0] dl);
    int n;
    @(posedge sys_clk);
    #2;
    go = 1'b1;
    write = wr;
    addr = a;
    delay = dl;
    @(posedge sys_clk);
    #2;
    go = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      chk("done", 16'h0001, 16'h0000);
      results();
    end
  endtask

  task automatic rdchk(input int gi, input logic [3:0] dl);
    logic [15:0] m;
    m = (gi == 1) ? 16'hFFFE : 16'hFFFF;
    access(1'b0, 16'(32'hF100 + gi), dl);
    chk("rdata", exp_word(gi) & m, data & m);
    chk("rd_err", {15'h0, gi < 0 || gi > 4}, {15'h0, err});
  endtask

  // New flags; out-of-range codes leave the last legal one
  task automatic setf(input sfb_pkg::sfb_flags_t v);
    @(posedge sys_clk);
    #2;
    flags = v;
    if (v.proc_code <= 5'h08) proc_l = v.proc_code;
    if (v.motor_type <= 3'h2) mot_l = v.motor_type;
  endtask

  task automatic t_walk();
    for (int i = 0; i < 36; i++) begin
      setf((i == 35) ? '1 : 35'h1 << i);
      for (int g = 0; g < 5; g++) begin
        rdchk(g, 4'(g));
      end
    end
  endtask

  task automatic t_codes();
    sfb_pkg::sfb_flags_t v;
    for (int k = 0; k < 32; k++) begin
      v = '0;
      v.proc_code = 5'(k);
      v.motor_type = 3'(k);
      setf(v);
      rdchk(2, 4'h0);
      rdchk(3, 4'h2);
    end
  endtask

  task automatic t_refuse();
    setf(35'h5A5A5A5A5);
    for (int g = -1; g < 6; g++) begin
      access(1'b1, 16'(32'hF100 + g), 4'h1);
      chk("wr_refused", 16'h0001, {15'h0, err});
      rdchk(g, 4'h0);
    end
  endtask

  task automatic t_hb();
    logic v;
    int n;
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      #1;
      v = heartbeat;
      n = 1;
      while (heartbeat === v && n < 40) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
    end
    chk("hb_half", 16'(HB), 16'(n));
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    t_walk();
    t_codes();
    t_refuse();
    t_hb();
    results();
  end
endmodule

`default_nettype wire
